// ===== acqcr_pkg.sv
// Package: constants and state type of the acquisition configuration bank
package acqcr_pkg;

    // ****************************************************************
    // Register offsets, masks and reset values
    // ****************************************************************
    localparam logic [4:0] ADDR_PIN_DIR     = 5'h06;
    localparam logic [4:0] ADDR_REF_OSC     = 5'h07;
    localparam logic [4:0] ADDR_SERIAL      = 5'h18;
    localparam logic [7:0] MASK_PIN_DIR     = 8'h0f;
    localparam logic [7:0] MASK_REF_OSC     = 8'h3f;
    localparam logic [7:0] MASK_SERIAL      = 8'he7;
    localparam logic [7:0] RST_PIN_DIR      = 8'h00;
    localparam logic [7:0] RST_REF_OSC      = 8'h00;
    localparam logic [7:0] RST_SERIAL       = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_OSC_SEL  = 5;  // Reference clock source select
    localparam int BIT_OSC_OE   = 4;  // Oscillator output enable
    localparam int BIT_REF_PWR  = 3;  // Reference power enable
    localparam int BIT_BUF_PWR  = 2;  // Reference buffer power enable
    localparam int BIT_LVL_SEL  = 1;  // Reference level select
    localparam int BIT_BANDGAP  = 0;  // Bandgap level select
    localparam int SER_LSB_HI   = 7;
    localparam int SER_LSB_LO   = 0;
    localparam int SER_WIRE_HI  = 6;
    localparam int SER_WIRE_LO  = 1;
    localparam int SER_EARLY_HI = 5;
    localparam int SER_EARLY_LO = 2;
    localparam int INSTR_MODE   = 7;  // 1 = direct conversion byte
    localparam int INSTR_READ   = 6;  // 1 = register read

    // Reference level codes
    localparam logic [1:0] LVL_2V5   = 2'h0;
    localparam logic [1:0] LVL_2V048 = 2'h1;
    localparam logic [1:0] LVL_1V15  = 2'h2;

    // Synchroniser slots
    localparam int SYN_CS   = 0;
    localparam int SYN_SCLK = 1;
    localparam int SYN_DIN  = 2;
    localparam int SYN_CONVERSION_CLOCK_PIN = 3;
    localparam int SYN_PINA = 4;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_FREQ_KHZ = 250000;
    localparam int OSC_FREQ_KHZ = 2500;
    localparam logic [6:0] OSC_HALF_CYCLES =
        7'(CLK_FREQ_KHZ / (2 * OSC_FREQ_KHZ));

    typedef enum logic [1:0] {
        PH_INSTR,
        PH_WRITE,
        PH_READ,
        PH_IGNORE
    } acqcr_phase_type;

    typedef struct packed {
        logic [4:0]      sync1;
        logic [4:0]      sync2;
        logic            sclk_d;
        logic            conv_d;
        logic [7:0]      pin_dir;
        logic [7:0]      ref_osc;
        logic [7:0]      serial;
        acqcr_phase_type phase;
        logic [2:0]      bitcnt;
        logic [7:0]      shreg;
        logic [7:0]      txreg;
        logic [4:0]      addr;
        logic            drive;
        logic            din_oe;
        logic            dout;
        logic [6:0]      osc_cnt;
        logic            osc_clk;
        logic            osc_power;
        logic            conversion_clock_pin_oe;
        logic [1:0]      div_cnt;
        logic            divided_conv_clock;
        logic            ref_clk;
        logic            ref_power;
        logic            buf_power;
        logic [1:0]      ref_level;
        logic            lsb_first;
        logic            two_wire;
        logic            early_rel;
    } acqcr_state_type;

    localparam acqcr_state_type STATE_RST = '0;

endpackage

// ===== acqcr_config_regs.sv
// Configuration register bank with its serial port and clock selection
`timescale 1ns/1ps
// Overview of operation
// - Pin-direction bit 1 makes its pin an output, 0 an input.
// - Source select 1 clocks the reference from the internal oscillator.
// - Source select 0 clocks the reference from the divided clock pin.
// - Oscillator output enable powers oscillator, drives its clock out.
// - Source select and reference power both 1 also run the oscillator.
// - Oscillator on when enable pin high or either oscillator condition holds.
// - Reference powered down at 0 (default), up at 1.
// - Reference buffer powered down at 0 (default), up at 1.
// - Bandgap select 1 gives 1.15 V and ignores level select.
// - Else level select 0 gives 2.5 V, 1 gives 2.048 V.
// - Serial control bits are mirrored; either copy set activates.
// - Bit order: 1 means LSB first, 0 (default) MSB first.
// - Wire count: 0 (default) 3-wire, 1 2-wire.
// - Early release floats data at last active edge, else later.
// - Write instruction 0x18 to serial control works in any bit order.
// - Oscillator enable and source select reset to zero.
// - Divide select divides the clock pin by 1, 2, 4 or 8.
// - In 2-wire mode read data drives both data pins.
module acqcr_config_regs (
    input  wire logic       I_CLK,                 // 250 MHz clock
    input  wire logic       I_RST_B,               // Async reset, low
    input  wire logic       I_CS_B,                // Chip select pin
    input  wire logic       I_SCLK,                // Serial clock pin
    input  wire logic       I_DIN,                 // Serial data in pin
    input  wire logic       I_CONVERSION_CLOCK_PIN,                // Conversion clock pin
    input  wire logic       I_OSC_PIN_A,           // Oscillator enable pin
    input  wire logic [1:0] I_CLOCK_DIVIDE_SELECT, // Divider setting
    output logic            O_DOUT,                // Serial data out level
    output logic            O_DOUT_OE,             // Data out driven
    output logic            O_DIN_OUT,             // Data in pin out level
    output logic            O_DIN_OE,              // Data in pin driven
    output logic [3:0]      O_GPIO_OE,             // Pin output enables
    output logic            O_CONVERSION_CLOCK_PIN_OUT,            // Oscillator clock out
    output logic            O_CONVERSION_CLOCK_PIN_OE,             // Clock pin driven
    output logic            O_OSC_POWER,           // Oscillator running
    output logic            O_DIVIDED_CONV_CLOCK,                // Divided clock
    output logic            O_REF_CLK,             // Reference clock
    output logic            O_REF_POWER,           // Reference powered
    output logic            O_REF_BUF_POWER,       // Buffer powered
    output logic [1:0]      O_REF_LEVEL,           // Reference level code
    output logic            O_LSB_FIRST,           // Bit order active
    output logic            O_TWO_WIRE,            // 2-wire mode active
    output logic            O_EARLY_RELEASE        // Early release active
);

    // ****************************************************************
    // State and decoded helpers
    // ****************************************************************
    acqcr_pkg::acqcr_state_type s;
    acqcr_pkg::acqcr_state_type next_s;

    logic       cs_b;
    logic       din;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       lsb_cfg;
    logic       wire_cfg;
    logic       early_cfg;
    logic [7:0] shifted;
    logic       last_bit;
    logic       conv_src;
    logic       conv_rise;
    logic [7:0] read_data;

    // Edges come from the second synchroniser stage only
    assign cs_b      = s.sync2[acqcr_pkg::SYN_CS];
    assign din       = s.sync2[acqcr_pkg::SYN_DIN];
    assign sclk_rise = s.sync2[acqcr_pkg::SYN_SCLK] & ~s.sclk_d;
    assign sclk_fall = ~s.sync2[acqcr_pkg::SYN_SCLK] & s.sclk_d;
    assign last_bit  = (s.bitcnt == 3'h7);

    // Mirrored copies, either one set turns the function on
    assign lsb_cfg   = s.serial[acqcr_pkg::SER_LSB_HI]
                     | s.serial[acqcr_pkg::SER_LSB_LO];
    assign wire_cfg  = s.serial[acqcr_pkg::SER_WIRE_HI]
                     | s.serial[acqcr_pkg::SER_WIRE_LO];
    assign early_cfg = s.serial[acqcr_pkg::SER_EARLY_HI]
                     | s.serial[acqcr_pkg::SER_EARLY_LO];

    // Shift direction follows the configured bit order
    assign shifted = lsb_cfg ? {din, s.shreg[7:1]}
                             : {s.shreg[6:0], din};

    // When the oscillator drives the pin, its own clock is the source
    assign conv_src  = s.ref_osc[acqcr_pkg::BIT_OSC_OE] ? s.osc_clk
                     : s.sync2[acqcr_pkg::SYN_CONVERSION_CLOCK_PIN];
    assign conv_rise = conv_src & ~s.conv_d;

    // Register read mux; unmapped addresses read as zero
    always_comb begin
        if (shifted[4:0] == acqcr_pkg::ADDR_PIN_DIR) begin
            read_data = s.pin_dir;
        end else if (shifted[4:0] == acqcr_pkg::ADDR_REF_OSC) begin
            read_data = s.ref_osc;
        end else if (shifted[4:0] == acqcr_pkg::ADDR_SERIAL) begin
            read_data = s.serial;
        end else begin
            read_data = 8'h00;
        end
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        next_s = s;
        next_s.sync1 = {I_OSC_PIN_A, I_CONVERSION_CLOCK_PIN, I_DIN, I_SCLK, I_CS_B};
        next_s.sync2 = s.sync1;
        next_s.sclk_d = s.sync2[acqcr_pkg::SYN_SCLK];
        next_s.conv_d = conv_src;

        // Serial port: chip select high aborts and floats the data pins
        if (cs_b) begin
            next_s.phase  = acqcr_pkg::PH_INSTR;
            next_s.bitcnt = 3'h0;
            next_s.drive  = 1'b0;
        end else if (sclk_rise) begin
            next_s.shreg  = shifted;
            next_s.bitcnt = s.bitcnt + 3'h1;
            if (last_bit) begin
                case (s.phase)
                    acqcr_pkg::PH_INSTR: begin
                        // Symmetric 0x18 decodes alike in either order
                        next_s.addr = shifted[4:0];
                        if (shifted[acqcr_pkg::INSTR_MODE]) begin
                            next_s.phase = acqcr_pkg::PH_IGNORE;
                        end else if (shifted[acqcr_pkg::INSTR_READ]) begin
                            next_s.phase = acqcr_pkg::PH_READ;
                            next_s.txreg = read_data;
                        end else begin
                            next_s.phase = acqcr_pkg::PH_WRITE;
                        end
                    end
                    acqcr_pkg::PH_WRITE: begin
                        // Reserved bits are masked so they read as zero
                        if (s.addr == acqcr_pkg::ADDR_PIN_DIR) begin
                            next_s.pin_dir = shifted
                                & acqcr_pkg::MASK_PIN_DIR;
                        end else if (s.addr == acqcr_pkg::ADDR_REF_OSC) begin
                            next_s.ref_osc = shifted
                                & acqcr_pkg::MASK_REF_OSC;
                        end else if (s.addr == acqcr_pkg::ADDR_SERIAL) begin
                            next_s.serial = shifted
                                & acqcr_pkg::MASK_SERIAL;
                        end
                        next_s.phase = acqcr_pkg::PH_INSTR;
                    end
                    acqcr_pkg::PH_READ: begin
                        // Early release floats on this active edge
                        if (early_cfg) begin
                            next_s.drive = 1'b0;
                        end
                        next_s.phase = acqcr_pkg::PH_INSTR;
                    end
                    default: begin
                        next_s.phase = acqcr_pkg::PH_INSTR;
                    end
                endcase
            end
        end else if (sclk_fall) begin
            // Read bits change on inactive edges; the next inactive
            // edge after the byte floats the pins
            if (s.phase == acqcr_pkg::PH_READ) begin
                next_s.drive = 1'b1;
                next_s.dout  = lsb_cfg ? s.txreg[0] : s.txreg[7];
                next_s.txreg = lsb_cfg ? {1'b0, s.txreg[7:1]}
                                       : {s.txreg[6:0], 1'b0};
            end else begin
                next_s.drive = 1'b0;
            end
        end
        // Data in pin joins the output only in 2-wire mode
        next_s.din_oe = next_s.drive & wire_cfg;

        // Oscillator runs for the pin or either oscillator condition
        next_s.osc_power = s.sync2[acqcr_pkg::SYN_PINA]
            | s.ref_osc[acqcr_pkg::BIT_OSC_OE]
            | (s.ref_osc[acqcr_pkg::BIT_OSC_SEL]
               & s.ref_osc[acqcr_pkg::BIT_REF_PWR]);
        if (s.osc_power) begin
            if (s.osc_cnt == acqcr_pkg::OSC_HALF_CYCLES - 7'h1) begin
                next_s.osc_cnt = 7'h0;
                next_s.osc_clk = ~s.osc_clk;
            end else begin
                next_s.osc_cnt = s.osc_cnt + 7'h1;
            end
        end else begin
            next_s.osc_cnt = 7'h0;
            next_s.osc_clk = 1'b0;
        end
        // Only the output enable bit turns the clock pin around
        next_s.conversion_clock_pin_oe = s.ref_osc[acqcr_pkg::BIT_OSC_OE];

        // Divider by 1, 2, 4 or 8 of the conversion clock
        if (I_CLOCK_DIVIDE_SELECT == 2'h0) begin
            next_s.divided_conv_clock    = conv_src;
            next_s.div_cnt = 2'h0;
        end else if (conv_rise) begin
            next_s.div_cnt = s.div_cnt + 2'h1;
            if ((I_CLOCK_DIVIDE_SELECT == 2'h1)
                || (I_CLOCK_DIVIDE_SELECT == 2'h2 && s.div_cnt[0])
                || (s.div_cnt == 2'h3)) begin
                next_s.divided_conv_clock    = ~s.divided_conv_clock;
            end
        end

        // Reference clock source selection
        next_s.ref_clk = s.ref_osc[acqcr_pkg::BIT_OSC_SEL]
                       ? s.osc_clk
                       : s.divided_conv_clock;
        next_s.ref_power = s.ref_osc[acqcr_pkg::BIT_REF_PWR];
        next_s.buf_power = s.ref_osc[acqcr_pkg::BIT_BUF_PWR];
        if (s.ref_osc[acqcr_pkg::BIT_BANDGAP]) begin
            next_s.ref_level = acqcr_pkg::LVL_1V15;
        end else if (s.ref_osc[acqcr_pkg::BIT_LVL_SEL]) begin
            next_s.ref_level = acqcr_pkg::LVL_2V048;
        end else begin
            next_s.ref_level = acqcr_pkg::LVL_2V5;
        end
        next_s.lsb_first = lsb_cfg;
        next_s.two_wire  = wire_cfg;
        next_s.early_rel = early_cfg;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // All configuration clears at reset, oscillator bits included
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            s <= acqcr_pkg::STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    // Outputs come straight from state flops
    assign O_DOUT          = s.dout;
    assign O_DOUT_OE       = s.drive;
    assign O_DIN_OUT       = s.dout;
    assign O_DIN_OE        = s.din_oe;
    assign O_GPIO_OE       = s.pin_dir[3:0];
    assign O_CONVERSION_CLOCK_PIN_OUT      = s.osc_clk;
    assign O_CONVERSION_CLOCK_PIN_OE       = s.conversion_clock_pin_oe;
    assign O_OSC_POWER     = s.osc_power;
    assign O_DIVIDED_CONV_CLOCK          = s.divided_conv_clock;
    assign O_REF_CLK       = s.ref_clk;
    assign O_REF_POWER     = s.ref_power;
    assign O_REF_BUF_POWER = s.buf_power;
    assign O_REF_LEVEL     = s.ref_level;
    assign O_LSB_FIRST     = s.lsb_first;
    assign O_TWO_WIRE      = s.two_wire;
    assign O_EARLY_RELEASE = s.early_rel;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);

    sequence q_write_pin_dir;
        !cs_b && sclk_rise && last_bit && s.phase == acqcr_pkg::PH_WRITE
        && s.addr == acqcr_pkg::ADDR_PIN_DIR;
    endsequence

    sequence q_last_read_bit;
        !cs_b && sclk_rise && last_bit && s.phase == acqcr_pkg::PH_READ;
    endsequence

    property p_gpio_dir;
        q_write_pin_dir |=> O_GPIO_OE == $past(shifted[3:0]);
    endproperty
    a_gpio_dir: assert property (p_gpio_dir)
        else $error("pin direction write not applied");

    property p_ref_clk_osc;
        s.ref_osc[acqcr_pkg::BIT_OSC_SEL] |=> O_REF_CLK == $past(s.osc_clk);
    endproperty
    a_ref_clk_osc: assert property (p_ref_clk_osc)
        else $error("reference clock not from oscillator");

    property p_ref_clk_div;
        !s.ref_osc[acqcr_pkg::BIT_OSC_SEL] |=> O_REF_CLK == $past(O_DIVIDED_CONV_CLOCK);
    endproperty
    a_ref_clk_div: assert property (p_ref_clk_div)
        else $error("reference clock not from divider");

    property p_conversion_clock_pin_oe;
        s.ref_osc[acqcr_pkg::BIT_OSC_OE] |=> O_CONVERSION_CLOCK_PIN_OE && O_OSC_POWER;
    endproperty
    a_conversion_clock_pin_oe: assert property (p_conversion_clock_pin_oe)
        else $error("oscillator output enable not applied");

    property p_osc_power;
        (s.ref_osc[acqcr_pkg::BIT_OSC_SEL] && s.ref_osc[acqcr_pkg::BIT_REF_PWR]
         && !s.ref_osc[acqcr_pkg::BIT_OSC_OE]) |=> O_OSC_POWER && !O_CONVERSION_CLOCK_PIN_OE;
    endproperty
    a_osc_power: assert property (p_osc_power)
        else $error("oscillator not run for reference");

    property p_osc_off;
        !O_OSC_POWER |=> !O_CONVERSION_CLOCK_PIN_OUT;
    endproperty
    a_osc_off: assert property (p_osc_off)
        else $error("oscillator clock runs while off");

    property p_bandgap;
        s.ref_osc[acqcr_pkg::BIT_BANDGAP]
            |=> O_REF_LEVEL == acqcr_pkg::LVL_1V15;
    endproperty
    a_bandgap: assert property (p_bandgap)
        else $error("bandgap level not selected");

    property p_mirror;
        s.serial[acqcr_pkg::SER_LSB_LO] |=> O_LSB_FIRST;
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("mirrored bit order copy ignored");

    property p_early_release;
        q_last_read_bit ##0 early_cfg |=> !O_DOUT_OE;
    endproperty
    a_early_release: assert property (p_early_release)
        else $error("data pin not released early");

    property p_two_wire;
        O_DIN_OE |-> O_DOUT_OE && O_DIN_OUT == O_DOUT;
    endproperty
    a_two_wire: assert property (p_two_wire)
        else $error("data in pin driven without data out");

endmodule

// ===== acqcr_host.sv
// Host model that drives the serial port of the configuration bank
`timescale 1ns/1ps
module acqcr_host (
    input  wire logic i_clk,  // Bench clock
    input  wire logic i_line, // Read data line seen by the host
    output logic      o_cs_b, // Chip select, active low
    output logic      o_sclk, // Serial clock, idles low
    output logic      o_din   // Host data level
);
    // Slow enough for the two-flop pin synchronisers
    localparam int HALF = 8;

    // ****************************************************************
    // Frame tasks
    // ****************************************************************
    initial begin
        o_cs_b = 1'b1;
        o_sclk = 1'b0;
        o_din  = 1'b0;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // Set data at the fall, the device takes it at the rise
    task automatic xbyte(input logic [7:0] tx, input logic lsb,
                         input logic rel, output logic [7:0] rx);
        for (int k = 0; k < 8; k++) begin
            o_sclk = 1'b0;
            // Released line flips so a stale level never passes
            o_din  = rel ? ~o_din : tx[lsb ? k : 7 - k];
            idle(HALF);
            rx[lsb ? k : 7 - k] = i_line;
            o_sclk = 1'b1;
            idle(HALF);
        end
    endtask

    // Leaves the frame open after the last rise for inspection
    task automatic access(input logic rd, input logic [4:0] addr,
                          input logic [7:0] wd, input logic lsb,
                          output logic [7:0] rdata);
        logic [7:0] ins;
        logic [7:0] unused;
        ins    = {1'b0, rd, 1'b0, addr};
        o_cs_b = 1'b0;
        idle(HALF);
        xbyte(ins, lsb, 1'b0, unused);
        xbyte(wd & {8{~rd}}, lsb, rd, rdata);
    endtask

    task automatic stop();
        o_sclk = 1'b0;
        idle(HALF);
        o_cs_b = 1'b1;
        idle(HALF);
    endtask
endmodule

// ===== tb.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tb;
    logic       I_CLK, I_RST_B, I_CONVERSION_CLOCK_PIN, I_OSC_PIN_A;
    logic [1:0] I_CLOCK_DIVIDE_SELECT, msel;
    logic       cs_b, sclk, host_din, lsb, two;
    logic       O_DOUT, O_DOUT_OE, O_DIN_OUT, O_DIN_OE, O_CONVERSION_CLOCK_PIN_OUT;
    logic       O_CONVERSION_CLOCK_PIN_OE, O_OSC_POWER, O_DIVIDED_CONV_CLOCK, O_REF_CLK, O_REF_POWER;
    logic       O_REF_BUF_POWER, O_LSB_FIRST, O_TWO_WIRE, O_EARLY_RELEASE;
    logic [3:0] O_GPIO_OE;
    logic [1:0] O_REF_LEVEL;
    logic [7:0] r;
    int         err_count, num_checks;
    wire        din_pin = O_DIN_OE ? O_DIN_OUT : host_din;
    // Undriven data out shows the inverse so a missed drive is caught
    wire        line    = two ? din_pin : (O_DOUT_OE ? O_DOUT : ~O_DOUT);
    wire        mon     = msel == 2'h0 ? O_DIVIDED_CONV_CLOCK :
                          (msel == 2'h1 ? O_REF_CLK : O_CONVERSION_CLOCK_PIN_OUT);
    wire [7:0]  ref_obs = {O_CONVERSION_CLOCK_PIN_OE, O_OSC_POWER, O_REF_POWER,
                           O_REF_BUF_POWER, 2'h0, O_REF_LEVEL};
    wire [2:0]  ser_obs = {O_LSB_FIRST, O_TWO_WIRE, O_EARLY_RELEASE};
    logic [7:0] ref_vals [10] = '{8'h00, 8'h04, 8'h08, 8'h02, 8'h03,
                                  8'h01, 8'h20, 8'h28, 8'h10, 8'h30};

    acqcr_config_regs acqcr_config_regs_i (.I_CLK(I_CLK),
        .I_RST_B(I_RST_B), .I_CS_B(cs_b), .I_SCLK(sclk), .I_DIN(din_pin),
        .I_CONVERSION_CLOCK_PIN(I_CONVERSION_CLOCK_PIN), .I_OSC_PIN_A(I_OSC_PIN_A),
        .I_CLOCK_DIVIDE_SELECT(I_CLOCK_DIVIDE_SELECT), .O_DOUT(O_DOUT),
        .O_DOUT_OE(O_DOUT_OE), .O_DIN_OUT(O_DIN_OUT), .O_DIN_OE(O_DIN_OE),
        .O_GPIO_OE(O_GPIO_OE), .O_CONVERSION_CLOCK_PIN_OUT(O_CONVERSION_CLOCK_PIN_OUT),
        .O_CONVERSION_CLOCK_PIN_OE(O_CONVERSION_CLOCK_PIN_OE), .O_OSC_POWER(O_OSC_POWER), .O_DIVIDED_CONV_CLOCK(O_DIVIDED_CONV_CLOCK),
        .O_REF_CLK(O_REF_CLK), .O_REF_POWER(O_REF_POWER),
        .O_REF_BUF_POWER(O_REF_BUF_POWER), .O_REF_LEVEL(O_REF_LEVEL),
        .O_LSB_FIRST(O_LSB_FIRST), .O_TWO_WIRE(O_TWO_WIRE),
        .O_EARLY_RELEASE(O_EARLY_RELEASE));
    acqcr_host acqcr_host_i (.i_clk(I_CLK), .i_line(line), .o_cs_b(cs_b),
        .o_sclk(sclk), .o_din(host_din));

    // ****************************************************************
    // Clocks and helpers
    // ****************************************************************
    initial begin
        I_CLK = 1'b0;
        forever #2 I_CLK = ~I_CLK;
    end
    // External conversion clock, 8 bench clocks a period
    always begin
        repeat (4) @(negedge I_CLK);
        I_CONVERSION_CLOCK_PIN = ~I_CONVERSION_CLOCK_PIN;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t ns saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        acqcr_host_i.access(1'b0, a, d, lsb, r);
        acqcr_host_i.stop();
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
        acqcr_host_i.access(1'b1, a, 8'h00, lsb, r);
        acqcr_host_i.stop();
        check(r, exp);
    endtask

    // Rise-to-rise spacing, skipping the first edge as a warm-up
    task automatic period(input logic [1:0] sel, input int exp);
        logic last;
        int   t [$];
        msel = sel;
        last = mon;
        for (int n = 0; n < 2000 && t.size() < 3; n++) begin
            @(negedge I_CLK);
            if (mon === 1'b1 && last === 1'b0) t.push_back(n);
            last = mon;
        end
        if (t.size() < 3) begin
            err_count++;
            results();
        end
        check(8'(t[2] - t[1]), 8'(exp));
    endtask

    // Expected power, oscillator and level outputs for a value
    function automatic logic [7:0] refx(input logic [7:0] v);
        logic [1:0] lv;
        lv = v[0] ? acqcr_pkg::LVL_1V15 :
             (v[1] ? acqcr_pkg::LVL_2V048 : acqcr_pkg::LVL_2V5);
        return {v[4], v[4] | (v[5] & v[3]), v[3], v[2], 2'h0, lv};
    endfunction

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {I_RST_B, I_CONVERSION_CLOCK_PIN, I_OSC_PIN_A, lsb, two} = 5'h00;
        I_CLOCK_DIVIDE_SELECT = 2'h0;
        msel = 2'h0;
        repeat (6) @(negedge I_CLK);
        I_RST_B = 1'b1;
        repeat (4) @(negedge I_CLK);
        check(ref_obs, 8'h00);
        check({O_GPIO_OE, 1'b0, ser_obs}, 8'h00);
        foreach (ref_vals[i]) begin
            wr(acqcr_pkg::ADDR_REF_OSC, ref_vals[i]);
            check(ref_obs, refx(ref_vals[i]));
            rdchk(acqcr_pkg::ADDR_REF_OSC, ref_vals[i]);
        end
        I_OSC_PIN_A = 1'b1;
        wr(acqcr_pkg::ADDR_REF_OSC, 8'h00);
        check({O_OSC_POWER, O_CONVERSION_CLOCK_PIN_OE}, 8'h02);
        I_OSC_PIN_A = 1'b0;
        for (int d = 0; d < 4; d++) begin
            I_CLOCK_DIVIDE_SELECT = 2'(d);
            period(2'h0, 8 << d);
            period(2'h1, 8 << d);
        end
        wr(acqcr_pkg::ADDR_REF_OSC, 8'h28);
        period(2'h1, 2 * acqcr_pkg::OSC_HALF_CYCLES);
        wr(acqcr_pkg::ADDR_REF_OSC, 8'h10);
        period(2'h2, 2 * acqcr_pkg::OSC_HALF_CYCLES);
        wr(acqcr_pkg::ADDR_SERIAL, 8'h01);
        lsb = 1'b1;
        check(ser_obs, 8'h04);
        wr(acqcr_pkg::ADDR_SERIAL, 8'h80);
        check(ser_obs, 8'h04);
        rdchk(acqcr_pkg::ADDR_SERIAL, 8'h80);
        wr(acqcr_pkg::ADDR_PIN_DIR, 8'h0a);
        check(O_GPIO_OE, 8'h0a);
        rdchk(acqcr_pkg::ADDR_PIN_DIR, 8'h0a);
        wr(acqcr_pkg::ADDR_SERIAL, 8'h42);
        {lsb, two} = 2'h1;
        check(ser_obs, 8'h02);
        acqcr_host_i.access(1'b1, acqcr_pkg::ADDR_PIN_DIR, 8'h00, lsb, r);
        check(r, 8'h0a);
        check({O_DIN_OE, O_DOUT_OE}, 8'h03);
        acqcr_host_i.stop();
        check({O_DIN_OE, O_DOUT_OE}, 8'h00);
        wr(acqcr_pkg::ADDR_SERIAL, 8'h66);
        check(ser_obs, 8'h03);
        acqcr_host_i.access(1'b1, acqcr_pkg::ADDR_SERIAL, 8'h00, lsb, r);
        check({O_DIN_OE, O_DOUT_OE}, 8'h00);
        check(r, 8'h66);
        acqcr_host_i.stop();
        rdchk(5'h09, 8'h00);
        wr(acqcr_pkg::ADDR_PIN_DIR, 8'h05);
        check(O_GPIO_OE, 8'h05);
        results();
    end
endmodule
